/* File: logic/ccr_pkg.sv */
// package: offsets, fields, resets and carrier types of the core register block
package ccr_pkg;
  // ----------------------------------------------------------------------
  // register offsets in the special-function space
  // ----------------------------------------------------------------------
  localparam logic [7:0] CCR_OFF_SPL    = 8'h81;
  localparam logic [7:0] CCR_OFF_WAIT   = 8'h92;
  localparam logic [7:0] CCR_OFF_SPH    = 8'h9B;
  localparam logic [7:0] CCR_OFF_AMODE  = 8'h9D;
  localparam logic [7:0] CCR_OFF_STATUS = 8'hC5;
  localparam logic [7:0] CCR_OFF_RELOC  = 8'hC6;
  localparam logic [7:0] CCR_OFF_GUARD  = 8'hC7;
  localparam logic [7:0] CCR_OFF_FLAGS  = 8'hD0;
  localparam logic [7:0] CCR_OFF_MAIN   = 8'hE0;
  localparam logic [7:0] CCR_OFF_AUX    = 8'hF0;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] CCR_RST_ZERO   = 8'h00;
  localparam logic [7:0] CCR_RST_WAIT   = 8'h07;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CCR_FL_CARRY   = 7;
  localparam int unsigned CCR_FL_HALF    = 6;
  localparam int unsigned CCR_FL_USER0   = 5;
  localparam int unsigned CCR_FL_BANK_HI = 4;
  localparam int unsigned CCR_FL_BANK_LO = 3;
  localparam int unsigned CCR_FL_SIGNED  = 2;
  localparam int unsigned CCR_FL_SPARE   = 1;
  localparam int unsigned CCR_FL_PARITY  = 0;
  localparam int unsigned CCR_ST_HIGH    = 6;
  localparam int unsigned CCR_ST_LOW     = 5;
  localparam int unsigned CCR_AM_UPPER   = 1;
  localparam int unsigned CCR_AM_STACK   = 2;
  localparam logic [7:0]  CCR_AM_WMASK   = 8'h03;

  // ----------------------------------------------------------------------
  // timed write guard
  // ----------------------------------------------------------------------
  localparam logic [7:0] CCR_GUARD_KEY1 = 8'hAA;
  localparam logic [7:0] CCR_GUARD_KEY2 = 8'h55;
  localparam logic [2:0] CCR_GUARD_WIN  = 3'h4;

  // ----------------------------------------------------------------------
  // carrier types and states
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccr_bus_req_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [2:0] sel;
    logic       val;
  } ccr_bit_req_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ccr_stk_req_t;

  typedef enum logic [0:0] {
    CCR_FS_IDLE = 1'b0,
    CCR_FS_WAIT = 1'b1
  } ccr_fetch_st_t;

  typedef enum logic [1:0] {
    CCR_GS_LOCK = 2'b00,
    CCR_GS_KEY1 = 2'b01,
    CCR_GS_OPEN = 2'b10
  } ccr_guard_st_t;
endpackage : ccr_pkg

/* File: logic/ccr_core_regs.sv */
// core special-function registers, stack addressing and fetch wait-state control
//
// Summary of operation
// - 8-bit main operand at E0, bit-addressable
// - 8-bit aux operand at F0, bit-addressable
// - flags word fields carry down to parity
// - push writes operand at pointer plus one
// - pop loads operand from current pointer
// - flat mode: high byte joins pointer
// - high-level bit follows high interrupt service
// - low-level bit follows low interrupt service
// - progress status read-only, resets to zero
// - four serial activity bits are reserved
// - fetch takes wait field plus one
// - wait setting resets to seven, upper unused
// - relocation holds data base, 2KB steps
// - relocation writes need timed guard sequence
// - large mode keeps 16-bit program addresses
// - flat mode: 20-bit program, wide stack
// - data space stays 16 bits always
// - mode field 00 large, 1x flat
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module ccr_core_regs
  import ccr_pkg::*;
#(
  parameter int unsigned WAIT_W = 4
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  // register port
  input  wire ccr_bus_req_t bus_i,
  output logic [7:0]        rdata_o,
  // core bit and alu update port
  input  wire ccr_bit_req_t bit_i,
  input  wire logic         alu_main_wr_i,
  input  wire logic [7:0]   alu_main_i,
  input  wire logic         alu_flags_wr_i,
  input  wire logic [7:0]   alu_flags_i,
  // stack operations
  input  wire logic         push_i,
  input  wire logic         pop_i,
  input  wire logic [7:0]   stk_rdata_i,
  output ccr_stk_req_t      stk_o,
  // interrupt service state
  input  wire logic         hp_active_i,
  input  wire logic         lp_active_i,
  // program fetch
  input  wire logic         fetch_req_i,
  input  wire logic [19:0]  pc_i,
  output logic [19:0]       prog_addr_o,
  output logic              fetch_rd_o,
  output logic              stall_o,
  output logic              fetch_done_o,
  // register contents towards the core
  output logic [7:0]        main_o,
  output logic [7:0]        aux_o,
  output logic [7:0]        flags_o,
  output logic              flat_mode_o,
  output logic [7:0]        xdata_base_o
);
  // ----------------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------------
  if (WAIT_W < 1 || WAIT_W > 8) begin : g_bad_width
    $error("wait field width must lie between 1 and 8");
  end

  // bit-replace helper shared by the three bit-addressable registers
  function automatic logic [7:0] bit_upd(input logic [7:0] cur, input logic [2:0] sel,
                                         input logic v);
    logic [7:0] r;
    r      = cur;
    r[sel] = v;
    return r;
  endfunction : bit_upd

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0]        main_ff, aux_ff, flags_ff, spl_ff, sph_ff, wait_ff;
  logic [7:0]        reloc_ff, amode_ff, status_ff, rdata_ff;
  ccr_stk_req_t      stk_ff;
  logic              pop_pend_ff, pop_load_ff;
  ccr_fetch_st_t     fst_ff;
  logic [WAIT_W-1:0] wcnt_ff;
  logic              stall_ff, done_ff, frd_ff;
  logic [19:0]       paddr_ff;
  ccr_guard_st_t     gst_ff;
  logic [2:0]        gwin_ff;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  wire wr_main   = bus_i.wr && bus_i.addr == CCR_OFF_MAIN;
  wire wr_aux    = bus_i.wr && bus_i.addr == CCR_OFF_AUX;
  wire wr_flags  = bus_i.wr && bus_i.addr == CCR_OFF_FLAGS;
  wire wr_spl    = bus_i.wr && bus_i.addr == CCR_OFF_SPL;
  wire wr_sph    = bus_i.wr && bus_i.addr == CCR_OFF_SPH;
  wire wr_wait   = bus_i.wr && bus_i.addr == CCR_OFF_WAIT;
  wire wr_amode  = bus_i.wr && bus_i.addr == CCR_OFF_AMODE;
  wire wr_reloc  = bus_i.wr && bus_i.addr == CCR_OFF_RELOC;
  wire wr_guard  = bus_i.wr && bus_i.addr == CCR_OFF_GUARD;
  wire bit_main  = bit_i.wr && bit_i.addr == CCR_OFF_MAIN;
  wire bit_aux   = bit_i.wr && bit_i.addr == CCR_OFF_AUX;
  wire bit_flags = bit_i.wr && bit_i.addr == CCR_OFF_FLAGS;

  // ----------------------------------------------------------------------
  // addressing mode
  // ----------------------------------------------------------------------
  // mode field decode
  wire flat = amode_ff[CCR_AM_UPPER];

  // ----------------------------------------------------------------------
  // stack pointer arithmetic
  // ----------------------------------------------------------------------
  wire  [15:0] sp_full = {sph_ff, spl_ff};
  wire  [15:0] sp_inc  = flat ? sp_full + 16'h0001 : {sph_ff, spl_ff + 8'h01};
  wire  [15:0] sp_dec  = flat ? sp_full - 16'h0001 : {sph_ff, spl_ff - 8'h01};
  wire  [15:0] stk_base = flat ? sp_full : {8'h00, spl_ff};
  wire  [15:0] push_addr = flat ? sp_inc : {8'h00, sp_inc[7:0]};
  wire         do_push   = push_i && !pop_i;
  wire         do_pop    = pop_i && !push_i;

  // ----------------------------------------------------------------------
  // main operand and auxiliary operand next values
  // ----------------------------------------------------------------------
  logic [7:0] nxt_main, nxt_aux, nxt_flags;

  // main operand writers; pop data lands last and wins
  assign nxt_main = pop_load_ff   ? stk_rdata_i :
                    wr_main       ? bus_i.wdata :
                    alu_main_wr_i ? alu_main_i  :
                    bit_main      ? bit_upd(main_ff, bit_i.sel, bit_i.val) : main_ff;
  assign nxt_aux  = wr_aux  ? bus_i.wdata :
                    bit_aux ? bit_upd(aux_ff, bit_i.sel, bit_i.val) : aux_ff;

  // ----------------------------------------------------------------------
  // flags word: parity is always recomputed from the next main operand
  // ----------------------------------------------------------------------
  logic [7:0] flags_raw;
  assign flags_raw = wr_flags       ? bus_i.wdata :
                     alu_flags_wr_i ? alu_flags_i :
                     bit_flags      ? bit_upd(flags_ff, bit_i.sel, bit_i.val) : flags_ff;
  assign nxt_flags = {flags_raw[CCR_FL_CARRY:CCR_FL_SPARE], ^nxt_main};

  // ----------------------------------------------------------------------
  // timed write guard for the relocation register
  // ----------------------------------------------------------------------
  ccr_guard_st_t nxt_gst;
  logic [2:0]    nxt_gwin;
  wire           reloc_ok = wr_reloc && gst_ff == CCR_GS_OPEN;

  always_comb begin
    nxt_gst  = gst_ff;
    nxt_gwin = gwin_ff;
    case (gst_ff)
      CCR_GS_LOCK: begin
        if (wr_guard && bus_i.wdata == CCR_GUARD_KEY1) begin
          nxt_gst = CCR_GS_KEY1;
        end
      end
      CCR_GS_KEY1: begin
        // any bus write other than the second key drops the sequence
        if (bus_i.wr) begin
          nxt_gst  = (wr_guard && bus_i.wdata == CCR_GUARD_KEY2) ? CCR_GS_OPEN : CCR_GS_LOCK;
          nxt_gwin = CCR_GUARD_WIN;
        end
      end
      CCR_GS_OPEN: begin
        nxt_gwin = gwin_ff - 3'h1;
        if (reloc_ok || gwin_ff == 3'h1) begin
          nxt_gst = CCR_GS_LOCK;
        end
      end
      default: nxt_gst = CCR_GS_LOCK;
    endcase
  end

  // ----------------------------------------------------------------------
  // fetch wait-state sequencer
  // ----------------------------------------------------------------------
  ccr_fetch_st_t     nxt_fst;
  logic [WAIT_W-1:0] nxt_wcnt;
  logic              nxt_done;

  always_comb begin
    nxt_fst  = fst_ff;
    nxt_wcnt = wcnt_ff;
    nxt_done = 1'b0;
    case (fst_ff)
      CCR_FS_IDLE: begin
        if (fetch_req_i) begin
          nxt_fst  = CCR_FS_WAIT;
          nxt_wcnt = wait_ff[WAIT_W-1:0];
        end
      end
      CCR_FS_WAIT: begin
        if (wcnt_ff == '0) begin
          nxt_fst  = CCR_FS_IDLE;
          nxt_done = 1'b1;
        end else begin
          nxt_wcnt = wcnt_ff - 1'b1;
        end
      end
      default: nxt_fst = CCR_FS_IDLE;
    endcase
  end

  // large keeps 16 bits, flat widens to 20
  wire [19:0] nxt_paddr = flat ? pc_i : {4'h0, pc_i[15:0]};

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    case (bus_i.addr)
      CCR_OFF_MAIN:   rd_mux = main_ff;
      CCR_OFF_AUX:    rd_mux = aux_ff;
      CCR_OFF_FLAGS:  rd_mux = flags_ff;
      CCR_OFF_SPL:    rd_mux = spl_ff;
      CCR_OFF_SPH:    rd_mux = sph_ff;
      CCR_OFF_WAIT:   rd_mux = wait_ff;
      CCR_OFF_AMODE:  rd_mux = amode_ff;
      CCR_OFF_STATUS: rd_mux = status_ff;
      CCR_OFF_RELOC:  rd_mux = reloc_ff;
      default:        rd_mux = CCR_RST_ZERO;  // unmapped and guard key read zero
    endcase
  end

  // ----------------------------------------------------------------------
  // operand registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      main_ff  <= CCR_RST_ZERO;
      aux_ff   <= CCR_RST_ZERO;
      flags_ff <= CCR_RST_ZERO;
    end else begin
      main_ff  <= nxt_main;
      aux_ff   <= nxt_aux;
      flags_ff <= nxt_flags;
    end
  end

  // ----------------------------------------------------------------------
  // stack pointer; a software write in the same cycle beats push or pop
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      spl_ff <= CCR_RST_ZERO;
      sph_ff <= CCR_RST_ZERO;
    end else begin
      spl_ff <= wr_spl ? bus_i.wdata : do_push ? sp_inc[7:0] : do_pop ? sp_dec[7:0] : spl_ff;
      sph_ff <= wr_sph ? bus_i.wdata : do_push ? sp_inc[15:8] : do_pop ? sp_dec[15:8] : sph_ff;
    end
  end

  // ----------------------------------------------------------------------
  // stack memory request; pop data returns one cycle after the read
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      stk_ff      <= '0;
      pop_pend_ff <= 1'b0;
      pop_load_ff <= 1'b0;
    end else begin
      stk_ff.wr    <= do_push;
      stk_ff.rd    <= do_pop;
      stk_ff.addr  <= do_push ? push_addr : stk_base;
      stk_ff.wdata <= main_ff;
      pop_pend_ff  <= do_pop;
      pop_load_ff  <= pop_pend_ff;
    end
  end

  // ----------------------------------------------------------------------
  // configuration and status registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      wait_ff   <= CCR_RST_WAIT;
      amode_ff  <= CCR_RST_ZERO;
      reloc_ff  <= CCR_RST_ZERO;
      status_ff <= CCR_RST_ZERO;
      gst_ff    <= CCR_GS_LOCK;
      gwin_ff   <= 3'h0;
    end else begin
      if (wr_wait) wait_ff <= {4'h0, bus_i.wdata[3:0]};
      // stack-mode indicator mirrors the mode field and is not writable
      if (wr_amode) amode_ff <= (bus_i.wdata & CCR_AM_WMASK) |
                                ({7'h00, bus_i.wdata[CCR_AM_UPPER]} << CCR_AM_STACK);
      // relocation base, only inside guard window
      if (reloc_ok) reloc_ff <= bus_i.wdata;
      // service state only, serial bits zero
      status_ff <= ({7'h00, hp_active_i} << CCR_ST_HIGH) | ({7'h00, lp_active_i} << CCR_ST_LOW);
      gst_ff    <= nxt_gst;
      gwin_ff   <= nxt_gwin;
    end
  end

  // ----------------------------------------------------------------------
  // fetch control and read data
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      fst_ff   <= CCR_FS_IDLE;
      wcnt_ff  <= '0;
      done_ff  <= 1'b0;
      stall_ff <= 1'b0;
      frd_ff   <= 1'b0;
      paddr_ff <= 20'h00000;
      rdata_ff <= CCR_RST_ZERO;
    end else begin
      fst_ff   <= nxt_fst;
      wcnt_ff  <= nxt_wcnt;
      done_ff  <= nxt_done;
      stall_ff <= nxt_fst == CCR_FS_WAIT;
      frd_ff   <= nxt_fst == CCR_FS_WAIT;
      if (fst_ff == CCR_FS_IDLE && fetch_req_i) paddr_ff <= nxt_paddr;
      rdata_ff <= bus_i.rd ? rd_mux : CCR_RST_ZERO;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign rdata_o      = rdata_ff;
  assign stk_o        = stk_ff;
  assign prog_addr_o  = paddr_ff;
  assign fetch_rd_o   = frd_ff;
  assign stall_o      = stall_ff;
  assign fetch_done_o = done_ff;
  assign main_o       = main_ff;
  assign aux_o        = aux_ff;
  assign flags_o      = flags_ff;
  assign flat_mode_o  = amode_ff[CCR_AM_STACK];
  assign xdata_base_o = reloc_ff;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  property p_main_write;
    bus_i.wr && bus_i.addr == CCR_OFF_MAIN && !pop_load_ff |=> main_o == $past(bus_i.wdata);
  endproperty
  a_main_write: assert property (p_main_write) else $error("main operand write lost");

  property p_aux_bit;
    bit_i.wr && bit_i.addr == CCR_OFF_AUX && !bus_i.wr |=> aux_o[$past(bit_i.sel)] == $past(bit_i.val);
  endproperty
  a_aux_bit: assert property (p_aux_bit) else $error("aux bit write lost");

  property p_parity;
    flags_o[CCR_FL_PARITY] == ^main_o;
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag does not match operand");

  property p_push;
    push_i && !pop_i && !bus_i.wr |=> stk_o.wr && stk_o.addr[7:0] == $past(spl_ff) + 8'h01
                                      && stk_o.wdata == $past(main_ff);
  endproperty
  a_push: assert property (p_push) else $error("push target wrong");

  property p_pop;
    pop_i && !push_i |=> stk_o.rd && stk_o.addr[7:0] == $past(spl_ff) ##2 main_o == $past(stk_rdata_i);
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not load operand");

  property p_flat_stack;
    flat && push_i && !pop_i |=> stk_o.addr == $past(sp_full) + 16'h0001;
  endproperty
  a_flat_stack: assert property (p_flat_stack) else $error("flat stack address wrong");

  property p_status;
    ##1 status_ff[CCR_ST_HIGH] == $past(hp_active_i)
        && status_ff[CCR_ST_LOW] == $past(lp_active_i)
        && status_ff[4:0] == 5'h00 && status_ff[7] == 1'b0;
  endproperty
  a_status: assert property (p_status) else $error("status bits wrong");

  property p_fetch_len;
    fst_ff == CCR_FS_IDLE && fetch_req_i && wait_ff[3:0] == 4'h0 |=> stall_o ##1 fetch_done_o && !stall_o;
  endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("single cycle fetch wrong");

  property p_fetch_stall;
    fst_ff == CCR_FS_IDLE && fetch_req_i && wait_ff[3:0] == 4'h7 |=> stall_o [*8] ##1 fetch_done_o;
  endproperty
  a_fetch_stall: assert property (p_fetch_stall) else $error("eight cycle fetch wrong");

  property p_reloc_guard;
    bus_i.wr && bus_i.addr == CCR_OFF_RELOC && gst_ff != CCR_GS_OPEN |=> $stable(xdata_base_o);
  endproperty
  a_reloc_guard: assert property (p_reloc_guard) else $error("unguarded relocation write");

  property p_large_addr;
    fst_ff == CCR_FS_IDLE && fetch_req_i && !flat |=> prog_addr_o[19:16] == 4'h0;
  endproperty
  a_large_addr: assert property (p_large_addr) else $error("large mode address too wide");

  c_push_pop:  cover property (push_i ##1 pop_i);
  c_guard_ok:  cover property (reloc_ok);
  c_long_wait: cover property (fetch_req_i && wait_ff[3:0] == 4'hF);
endmodule : ccr_core_regs

/* File: testbench/testbench.sv */
// self-checking bench for the core register block
`timescale 1ns/1ps
module testbench;
  import ccr_pkg::*;
  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  logic         mclk_i, nrst_i;
  ccr_bus_req_t bus_i;
  ccr_bit_req_t bit_i;
  logic         alu_main_wr_i, alu_flags_wr_i, push_i, pop_i;
  logic         hp_active_i, lp_active_i, fetch_req_i;
  logic [7:0]   alu_main_i, alu_flags_i, stk_rdata_i, rdata_o;
  logic [19:0]  pc_i, prog_addr_o;
  ccr_stk_req_t stk_o;
  logic         fetch_rd_o, stall_o, fetch_done_o, flat_mode_o;
  logic [7:0]   main_o, aux_o, flags_o, xdata_base_o;
  int           mismatches = 0;
  int           cmp_count = 0;

  ccr_core_regs u_ccr_core_regs (.mclk_i, .nrst_i, .bus_i, .rdata_o, .bit_i, .alu_main_wr_i,
    .alu_main_i, .alu_flags_wr_i, .alu_flags_i, .push_i, .pop_i, .stk_rdata_i, .stk_o,
    .hp_active_i, .lp_active_i, .fetch_req_i, .pc_i, .prog_addr_o, .fetch_rd_o, .stall_o,
    .fetch_done_o, .main_o, .aux_o, .flags_o, .flat_mode_o, .xdata_base_o);

  // free-running core clock, 8 ns period
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i) bus_i <= {1'b1, 1'b0, a, d};
    @(posedge mclk_i) bus_i <= '0;
  endtask : wr

  // read data is only valid in the cycle after the strobe
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i) bus_i <= {1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_i) bus_i <= '0;
    #1 chk(nm, 32'(rdata_o), 32'(e));
  endtask : rchk

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // reset register values
  task automatic t_reset();
    rchk("main", CCR_OFF_MAIN, 8'h00);
    rchk("aux", CCR_OFF_AUX, 8'h00);
    rchk("flags", CCR_OFF_FLAGS, 8'h00);
    rchk("spl", CCR_OFF_SPL, 8'h00);
    rchk("sph", CCR_OFF_SPH, 8'h00);
    rchk("status", CCR_OFF_STATUS, 8'h00);
    rchk("wait", CCR_OFF_WAIT, 8'h07);
    rchk("reloc", CCR_OFF_RELOC, 8'h00);
    rchk("unmapped", 8'h80, 8'h00);
  endtask : t_reset

  task automatic t_rw();
    wr(CCR_OFF_AUX, 8'h5A);
    rchk("aux", CCR_OFF_AUX, 8'h5A);
    @(posedge mclk_i) bit_i <= {1'b1, CCR_OFF_AUX, 3'h0, 1'b1};
    @(posedge mclk_i) bit_i <= '0;
    #1 chk("aux bit", 32'(aux_o), 32'h5B);
    wr(CCR_OFF_MAIN, 8'h01);
    wr(CCR_OFF_FLAGS, 8'hFE);
    rchk("flags", CCR_OFF_FLAGS, 8'hFF);
    @(posedge mclk_i) bit_i <= {1'b1, CCR_OFF_MAIN, 3'h7, 1'b1};
    @(posedge mclk_i) bit_i <= '0;
    #1 chk("bit", 32'(main_o), 32'h81);
    @(posedge mclk_i);
    alu_main_wr_i  <= 1'b1;
    alu_main_i     <= 8'h07;
    alu_flags_wr_i <= 1'b1;
    alu_flags_i    <= 8'h80;
    @(posedge mclk_i);
    alu_main_wr_i  <= 1'b0;
    alu_flags_wr_i <= 1'b0;
    #1 chk("alu", 32'({main_o, flags_o}), 32'h0781);
    wr(CCR_OFF_WAIT, 8'hFF);
    rchk("wait", CCR_OFF_WAIT, 8'h0F);
  endtask : t_rw

  task automatic t_status();
    @(posedge mclk_i) hp_active_i <= 1'b1;
    wr(CCR_OFF_STATUS, 8'hFF);
    rchk("high", CCR_OFF_STATUS, 8'h40);
    @(posedge mclk_i);
    hp_active_i <= 1'b0;
    lp_active_i <= 1'b1;
    rchk("low", CCR_OFF_STATUS, 8'h20);
    @(posedge mclk_i) lp_active_i <= 1'b0;
  endtask : t_status

  task automatic t_guard();
    wr(CCR_OFF_RELOC, 8'h01);
    rchk("locked", CCR_OFF_RELOC, 8'h00);
    wr(CCR_OFF_GUARD, CCR_GUARD_KEY1);
    wr(CCR_OFF_GUARD, CCR_GUARD_KEY2);
    wr(CCR_OFF_RELOC, 8'h01);
    rchk("opened", CCR_OFF_RELOC, 8'h01);
    wr(CCR_OFF_RELOC, 8'h00);
    #1 chk("relock", 32'(xdata_base_o), 32'h01);
    // a foreign write between the keys must drop the sequence
    wr(CCR_OFF_GUARD, CCR_GUARD_KEY1);
    wr(CCR_OFF_AUX, 8'h5B);
    wr(CCR_OFF_GUARD, CCR_GUARD_KEY2);
    wr(CCR_OFF_RELOC, 8'h02);
    #1 chk("broken", 32'(xdata_base_o), 32'h01);
    // software puts relocation back to zero
    wr(CCR_OFF_GUARD, CCR_GUARD_KEY1);
    wr(CCR_OFF_GUARD, CCR_GUARD_KEY2);
    wr(CCR_OFF_RELOC, 8'h00);
    #1 chk("restored", 32'(xdata_base_o), 32'h00);
  endtask : t_guard

  task automatic t_stack();
    wr(CCR_OFF_SPH, 8'h12);
    wr(CCR_OFF_SPL, 8'h10);
    wr(CCR_OFF_MAIN, 8'hA5);
    @(posedge mclk_i) push_i <= 1'b1;
    @(posedge mclk_i) push_i <= 1'b0;
    #1 chk("push", 32'(stk_o), 32'({2'b10, 16'h0011, 8'hA5}));
    @(posedge mclk_i) pop_i <= 1'b1;
    @(posedge mclk_i) pop_i <= 1'b0;
    #1 chk("pop", 32'({stk_o.wr, stk_o.rd, stk_o.addr}), 32'({2'b01, 16'h0011}));
    @(posedge mclk_i) stk_rdata_i <= 8'h3C;
    @(posedge mclk_i) stk_rdata_i <= 8'hC3;
    #1 chk("popped", 32'(main_o), 32'h3C);
    rchk("spl", CCR_OFF_SPL, 8'h10);
    wr(CCR_OFF_AMODE, 8'h02);
    wr(CCR_OFF_SPL, 8'hFF);
    @(posedge mclk_i) push_i <= 1'b1;
    @(posedge mclk_i) push_i <= 1'b0;
    #1 chk("flat push", 32'(stk_o), 32'({2'b10, 16'h1300, 8'h3C}));
    rchk("sph", CCR_OFF_SPH, 8'h13);
    rchk("amode", CCR_OFF_AMODE, 8'h06);
  endtask : t_stack

  task automatic t_fetch(input logic [3:0] w, input logic [7:0] am);
    int n;
    wr(CCR_OFF_WAIT, {4'h0, w});
    wr(CCR_OFF_AMODE, am);
    @(posedge mclk_i);
    fetch_req_i <= 1'b1;
    pc_i        <= 20'hABCDE;
    @(posedge mclk_i) fetch_req_i <= 1'b0;
    n = 0;
    #1 chk("paddr", 32'(prog_addr_o), am[1] ? 32'hABCDE : 32'h0BCDE);
    chk("mode", 32'(flat_mode_o), 32'(am[1]));
    chk("fetch rd", 32'(fetch_rd_o), 32'h1);
    // a request during the stall must be ignored
    fetch_req_i <= 1'b1;
    while (stall_o === 1'b1 && n < 40) begin
      n++;
      @(posedge mclk_i);
      #1;
    end
    fetch_req_i <= 1'b0;
    chk("cycles", 32'(n), 32'(w) + 32'h1);
    chk("done", 32'(fetch_done_o), 32'h1);
    @(posedge mclk_i);
    #1 chk("no refetch", 32'(stall_o), 32'h0);
  endtask : t_fetch

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    nrst_i = 1'b0;
    bus_i = '0;
    bit_i = '0;
    {alu_main_wr_i, alu_flags_wr_i, push_i, pop_i} = 4'h0;
    {hp_active_i, lp_active_i, fetch_req_i} = 3'h0;
    {alu_main_i, alu_flags_i, stk_rdata_i} = 24'h000000;
    pc_i = 20'h00000;
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_rw();
    t_status();
    t_guard();
    t_stack();
    // settings above one, bar the single-cycle probe
    t_fetch(4'h0, 8'h00);
    t_fetch(4'hF, 8'h01);
    t_fetch(4'h7, 8'h02);
    t_fetch(4'h3, 8'h03);
    results();
  end

  // the run takes well under a thousand cycles
  initial begin
    repeat (4000) @(posedge mclk_i);
    mismatches++;
    $display("MISMATCH watchdog expected end seen hang");
    results();
  end
endmodule : testbench
